// ===== rtl/flash_host_pkg.sv
// constants, types and pin bundles for the parallel flash bus host
// Functional notes
// R1: read holds select and output enable low, write enable and reset high.
// R2: write drives write enable and select low, output enable high.
// R3: command register has no address; host just writes command cycles.
// R4: width select high gives sixteen active data pins.
// R5: width select low: eight data pins, pins 8-14 off, pin 15 is byte address.
// R6: word mode decodes address 17..0, byte mode adds bit below 0.
// R7: after power-up or reset device reads array without any command.
// R8: device stays in read-array until a write changes its command register.
// R9: unlock bypass programs with two write cycles, otherwise four.
// R10: erase covers one sector, several sectors or the whole memory.
// R11: identification reads return internal codes on the low eight pins.
// R12: reads during program or erase return status on the low eight pins.
// R13: select and reset both high put the device in standby, outputs floated.
// R14: deselecting during program or erase does not stop the operation.
// R15: device sleeps on stable address, keeps data, new address needs access.
// R16: reset low for the minimum pulse aborts, floats outputs, ignores cycles.
// R17: host reissues a program or erase that a reset interrupted; this host only flags it on INTERRUPTED_OUT.
// R18: reset during an algorithm keeps ready_busy_n low until reset completes.
// R19: host waits reset high recovery before starting a read.
// R20: protect: reset at high voltage, write with address 6 low, 1 high, 0 low.
// R21: unprotect: reset at high voltage, write with 6 high, 1 high, 0 low.
// R22: address taken on later falling select/write edge, data on earlier rise.
package flash_host_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CNT_W = 12;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SELECT_ACCESS_NS = 70;
  localparam int WRITE_PULSE_NS = 35;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_HIGH_NS = 50;
  localparam int HV_SETUP_NS = 4000;
  // least times, rounded up to whole clocks
  localparam int SELECT_ACCESS_CYC =
    (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HIGH_CYC =
    (RESET_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HV_SETUP_CYC =
    (HV_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = SELECT_ACCESS_CYC + SYNC_STAGES;
  localparam int SECT_SEL_BIT = 6;
  localparam int SECT_MID_BIT = 1;
  localparam int SECT_LOW_BIT = 0;
  localparam logic [DATA_W-1:0] BYTE_OE_N = 16'h7f00;
  localparam logic [DATA_W-1:0] WORD_OE_N = 16'h0000;
  localparam logic [DATA_W-1:0] FLOAT_OE_N = 16'hffff;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_RESET, OP_PROTECT, OP_UNPROTECT
  } op_t;

  typedef struct packed {
    op_t op;
    logic byte_mode;
    logic [ADDR_W-1:0] addr;
    logic byte_lsb;
    logic [DATA_W-1:0] data;
  } req_t;

  typedef struct packed {
    logic select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic hw_reset_n;
    logic reset_hv;
    logic width_select_n;
  } pins_t;

  localparam pins_t PINS_IDLE = '{select_n: 1'b1, output_enable_n: 1'b1,
    write_enable_n: 1'b1, hw_reset_n: 1'b1, reset_hv: 1'b0,
    width_select_n: 1'b1};
endpackage : flash_host_pkg

// ===== rtl/flash_host.sv
// host controller driving the parallel flash bus pins
`timescale 1ns/100ps
module flash_host (
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic REQ_VALID_IN,
  input wire flash_host_pkg::req_t REQ_IN,
  output logic REQ_READY_OUT,
  output logic RSP_VALID_OUT,
  output logic [flash_host_pkg::DATA_W-1:0] RSP_DATA_OUT,
  output logic INTERRUPTED_OUT,
  output logic DEVICE_BUSY_OUT,
  output flash_host_pkg::pins_t PINS_OUT,
  output logic [flash_host_pkg::ADDR_W-1:0] ADDR_OUT,
  output logic [flash_host_pkg::DATA_W-1:0] DQ_OUT,
  output logic [flash_host_pkg::DATA_W-1:0] DQ_OE_N_OUT,
  input wire logic [flash_host_pkg::DATA_W-1:0] DQ_IN,
  input wire logic READY_BUSY_N_IN
);
  import flash_host_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_WAIT, ST_HV_RISE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
    ST_HV_FALL, ST_RST_PULSE, ST_RST_RECOVER, ST_READY_WAIT
  } state_t;

  state_t state, next_state;
  pins_t ctl, next_ctl;
  req_t cur, next_cur;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] dq, next_dq;
  logic [DATA_W-1:0] dq_oe_n, next_dq_oe_n;
  logic [DATA_W-1:0] rsp_data, next_rsp_data;
  logic rsp_valid, next_rsp_valid;
  logic interrupted, next_interrupted;
  logic [DATA_W-1:0] dq_meta, dq_sync;
  logic rb_meta, rb_sync;

  // byte mode puts the byte address on the top data pin
  function automatic logic [DATA_W-1:0] write_word(input req_t r);
    logic [DATA_W-1:0] w;
    w = r.data;
    if (r.byte_mode) begin
      w = {r.byte_lsb, 7'h00, r.data[7:0]}; // [R5] [R6]
    end
    return w;
  endfunction : write_word

  // pin 15 stays driven in byte mode, even during reads
  function automatic logic [DATA_W-1:0] read_oe_n(input logic byte_mode);
    return byte_mode ? 16'h7fff : FLOAT_OE_N; // [R5]
  endfunction : read_oe_n

  function automatic logic [ADDR_W-1:0] hv_addr(input req_t r);
    logic [ADDR_W-1:0] a;
    a = r.addr;
    a[SECT_SEL_BIT] = (r.op == OP_UNPROTECT); // [R20] [R21]
    a[SECT_MID_BIT] = 1'b1; // [R20] [R21]
    a[SECT_LOW_BIT] = 1'b0; // [R20] [R21]
    return a;
  endfunction : hv_addr

  always_ff @(posedge CORE_CLK_IN) begin
    dq_meta <= DQ_IN;
    dq_sync <= dq_meta;
    rb_meta <= READY_BUSY_N_IN;
    rb_sync <= rb_meta;
  end

  always_comb begin
    next_state = state;
    next_ctl = ctl;
    next_cur = cur;
    next_cnt = (cnt == '0) ? cnt : cnt - 1'b1;
    next_addr = addr;
    next_dq = dq;
    next_dq_oe_n = dq_oe_n;
    next_rsp_data = rsp_data;
    next_rsp_valid = 1'b0;
    next_interrupted = interrupted;
    case (state)
      ST_IDLE: begin
        // idle parks select and reset high so the device sits in standby
        next_ctl = PINS_IDLE; // [R13]
        next_ctl.width_select_n = ~cur.byte_mode;
        if (REQ_VALID_IN) begin
          next_cur = REQ_IN;
          next_ctl.width_select_n = ~REQ_IN.byte_mode; // [R4] [R5]
          next_addr = REQ_IN.addr; // [R6]
          next_dq = write_word(REQ_IN);
          case (REQ_IN.op)
            OP_READ: begin
              // a full select access is waited on every read, standby or not
              next_ctl.select_n = 1'b0; // [R1] [R13] [R15]
              next_ctl.output_enable_n = 1'b0; // [R1] [R7]
              next_dq_oe_n = read_oe_n(REQ_IN.byte_mode);
              next_cnt = CNT_W'(READ_CYC - 1);
              next_state = ST_RD_WAIT;
            end
            OP_WRITE: begin
              next_ctl.select_n = 1'b0; // [R2] [R3]
              next_dq_oe_n = REQ_IN.byte_mode ? BYTE_OE_N : WORD_OE_N;
              next_interrupted = 1'b0;
              next_state = ST_WR_SETUP;
            end
            OP_RESET: begin
              next_ctl.hw_reset_n = 1'b0; // [R16]
              next_cnt = CNT_W'(RESET_PULSE_CYC - 1);
              next_interrupted = interrupted | ~rb_sync; // [R17]
              next_state = ST_RST_PULSE;
            end
            OP_PROTECT, OP_UNPROTECT: begin
              next_ctl.reset_hv = 1'b1; // [R20] [R21]
              next_addr = hv_addr(REQ_IN);
              next_cnt = CNT_W'(HV_SETUP_CYC - 1);
              next_state = ST_HV_RISE;
            end
            default: begin
              next_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_RD_WAIT: begin
        if (cnt == '0) begin
          next_rsp_data = cur.byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync;
          next_rsp_valid = 1'b1; // [R1]
          next_ctl.select_n = 1'b1;
          next_ctl.output_enable_n = 1'b1;
          next_dq_oe_n = FLOAT_OE_N;
          next_state = ST_IDLE;
        end
      end
      ST_HV_RISE: begin
        if (cnt == '0) begin
          next_ctl.select_n = 1'b0; // [R20] [R21]
          next_dq_oe_n = cur.byte_mode ? BYTE_OE_N : WORD_OE_N; // [R5]
          next_state = ST_WR_SETUP;
        end
      end
      ST_WR_SETUP: begin
        // address and data are already steady when write enable falls
        next_ctl.write_enable_n = 1'b0; // [R2] [R22]
        next_cnt = CNT_W'(WRITE_PULSE_CYC - 1);
        next_state = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (cnt == '0) begin
          next_ctl.write_enable_n = 1'b1; // [R22]
          next_state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // data released one clock after the rising edge
        next_ctl.select_n = 1'b1; // [R22]
        next_ctl.reset_hv = 1'b0;
        next_dq_oe_n = FLOAT_OE_N;
        if (ctl.reset_hv) begin
          next_cnt = CNT_W'(RESET_HIGH_CYC - 1);
          next_state = ST_HV_FALL;
        end else begin
          next_rsp_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_HV_FALL: begin
        if (cnt == '0) begin
          next_rsp_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_RST_PULSE: begin
        if (cnt == '0) begin
          next_ctl.hw_reset_n = 1'b1;
          next_cnt = CNT_W'(RESET_HIGH_CYC - 1); // [R19]
          next_state = ST_RST_RECOVER;
        end
      end
      ST_RST_RECOVER: begin
        if (cnt == '0) begin
          next_state = ST_READY_WAIT;
        end
      end
      ST_READY_WAIT: begin
        // an aborted algorithm keeps the device busy a while longer
        if (rb_sync) begin // [R18]
          next_rsp_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_ctl = PINS_IDLE;
        next_dq_oe_n = FLOAT_OE_N;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      state <= ST_IDLE;
      ctl <= PINS_IDLE;
      cur <= '0;
      cnt <= '0;
      addr <= '0;
      dq <= '0;
      dq_oe_n <= FLOAT_OE_N;
      rsp_data <= '0;
      rsp_valid <= 1'b0;
      interrupted <= 1'b0;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
      cur <= next_cur;
      cnt <= next_cnt;
      addr <= next_addr;
      dq <= next_dq;
      dq_oe_n <= next_dq_oe_n;
      rsp_data <= next_rsp_data;
      rsp_valid <= next_rsp_valid;
      interrupted <= next_interrupted;
    end
  end

  assign REQ_READY_OUT = (state == ST_IDLE);
  assign RSP_VALID_OUT = rsp_valid;
  assign RSP_DATA_OUT = rsp_data;
  assign INTERRUPTED_OUT = interrupted;
  assign DEVICE_BUSY_OUT = ~rb_sync;
  assign PINS_OUT = ctl;
  assign ADDR_OUT = addr;
  assign DQ_OUT = dq;
  assign DQ_OE_N_OUT = dq_oe_n;

  // helper: length of the current reset low pulse
  logic [CNT_W-1:0] low_run;
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN || ctl.hw_reset_n) begin
      low_run <= '0;
    end else begin
      low_run <= low_run + 1'b1;
    end
  end

  localparam int RD_GAP = READ_CYC;
  localparam int RECOV_D = RESET_HIGH_CYC;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);

  sequence s_read_taken;
    REQ_READY_OUT && REQ_VALID_IN && REQ_IN.op == OP_READ;
  endsequence
  sequence s_reset_release;
    $rose(ctl.hw_reset_n);
  endsequence

  AST_READ_LEVELS: assert property (!ctl.output_enable_n |-> // [R1]
    !ctl.select_n && ctl.write_enable_n && ctl.hw_reset_n)
    else $error("read cycle with bad control levels");
  AST_READ_RESULT: assert property (s_read_taken |-> // [R1]
    ##1 !ctl.output_enable_n ##RD_GAP RSP_VALID_OUT)
    else $error("read answer not on time");
  AST_WRITE_LEVELS: assert property (!ctl.write_enable_n |-> // [R2]
    !ctl.select_n && ctl.output_enable_n && dq_oe_n[7:0] == 8'h00)
    else $error("write cycle with bad control levels");
  AST_BYTE_FLOAT: assert property (!ctl.width_select_n && // [R5]
    !ctl.select_n |-> dq_oe_n[14:8] == 7'h7f && !dq_oe_n[15])
    else $error("byte mode pins misdriven");
  AST_RESET_WIDTH: assert property ($rose(ctl.hw_reset_n) |-> // [R16]
    low_run >= CNT_W'(RESET_PULSE_CYC))
    else $error("reset pulse too short");
  AST_RECOVERY: assert property (s_reset_release |-> // [R19]
    ctl.select_n throughout (##RECOV_D 1'b1))
    else $error("access started inside reset recovery");
  AST_PROTECT_ADDR: assert property (ctl.reset_hv && !ctl.write_enable_n
    && cur.op == OP_PROTECT |-> !addr[6] && addr[1] && !addr[0]) // [R20]
    else $error("protect write with wrong address bits");
  AST_UNPROTECT_ADDR: assert property (ctl.reset_hv && !ctl.write_enable_n
    && cur.op == OP_UNPROTECT |-> addr[6] && addr[1] && !addr[0]) // [R21]
    else $error("unprotect write with wrong address bits");
  AST_DATA_HOLD: assert property ($rose(ctl.write_enable_n) |-> // [R22]
    !ctl.select_n && $stable(dq) ##1 ctl.select_n)
    else $error("write data not held past write edge");
  AST_STANDBY: assert property (state == ST_IDLE |-> // [R13]
    ctl.select_n && ctl.hw_reset_n && dq_oe_n == FLOAT_OE_N)
    else $error("idle bus not in standby");
endmodule : flash_host

// ===== verification/flash_dev_model.sv
// behavioural model of the parallel flash device on the host's pins
`timescale 1ns/100ps
module flash_dev_model (
  input wire logic clk_in,
  input wire flash_host_pkg::pins_t pins_in,
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
  output logic [flash_host_pkg::DATA_W-1:0] dq_out,
  output logic ready_busy_n_out
);
  import flash_host_pkg::*;
  // short embedded times keep the run brief
  localparam int BUSY_CYC = 300;
  localparam int RST_BUSY_CYC = 200;
  // arbitrary identification value and entry code, not any real part's
  localparam logic [7:0] ID_CODE = 8'h5a;
  localparam logic [7:0] ID_ENTER = 8'h3c;
  logic wr_on = 1'b0;
  logic id_mode = 1'b0;
  logic rst_on = 1'b0;
  logic wr_hv = 1'b0;
  logic [ADDR_W-1:0] wr_addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic [DATA_W-1:0] word, mask, val;
  int busy_cnt = 0;
  wire read_on = !pins_in.select_n && !pins_in.output_enable_n &&
    pins_in.write_enable_n && pins_in.hw_reset_n;
  wire wr_now = !pins_in.select_n && !pins_in.write_enable_n &&
    pins_in.hw_reset_n;
  assign ready_busy_n_out = (busy_cnt == 0);
  initial dq_out = '0;
  always_comb begin
    word = addr_in[15:0] ^ 16'ha5c3;
    if (id_mode) begin
      word = {8'h00, ID_CODE};
    end
    if (busy_cnt > 0) begin
      word = 16'h0080;
    end
    mask = pins_in.width_select_n ? 16'hffff : 16'h00ff;
    val = word;
    if (!pins_in.width_select_n && dq_in[15]) begin
      val = {8'h00, word[15:8]};
    end
    if (!read_on) begin
      mask = '0;
    end
  end
  // released bits toggle so a stale value never passes for data
  always @(posedge clk_in) begin
    dq_out <= (val & mask) | (~dq_out & ~mask);
    rst_on <= !pins_in.hw_reset_n;
    wr_on <= wr_now;
    if (!wr_on && wr_now) begin
      wr_addr <= addr_in;
      wr_hv <= pins_in.reset_hv;
    end
    if (wr_on && !wr_now) begin
      wr_data <= dq_in;
      id_mode <= !wr_hv && (dq_in[7:0] == ID_ENTER);
      busy_cnt <= wr_hv ? 0 : BUSY_CYC;
    end else if (!pins_in.hw_reset_n && !rst_on && busy_cnt > 0) begin
      busy_cnt <= RST_BUSY_CYC;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
    if (!pins_in.hw_reset_n) begin
      id_mode <= 1'b0;
    end
  end
endmodule : flash_dev_model

// ===== verification/flash_host_tb.sv
// self-checking testbench for the flash bus host
`timescale 1ns/100ps
module flash_host_tb;
  import flash_host_pkg::*;
  logic clk, srst, vld, rdy, rv, intr, dbusy, rbn;
  req_t req;
  op_t po;
  pins_t pins;
  logic [ADDR_W-1:0] ad, a, e;
  logic [DATA_W-1:0] rd, dq_o, dq_oe_n, dq_d, dq_i, w, last_rd;
  logic [DATA_W-1:0] exp_q[$];
  logic [31:0] seed = 32'h2eee9e0f;
  logic [31:0] r;
  int bad_count = 0;
  int checks_done = 0;
  assign dq_i = (~dq_oe_n & dq_o) | (dq_oe_n & dq_d);
  flash_host u_dut (.CORE_CLK_IN(clk), .SRST_IN(srst), .REQ_VALID_IN(vld),
    .REQ_IN(req), .REQ_READY_OUT(rdy), .RSP_VALID_OUT(rv),
    .RSP_DATA_OUT(rd), .INTERRUPTED_OUT(intr), .DEVICE_BUSY_OUT(dbusy),
    .PINS_OUT(pins), .ADDR_OUT(ad), .DQ_OUT(dq_o), .DQ_OE_N_OUT(dq_oe_n),
    .DQ_IN(dq_i), .READY_BUSY_N_IN(rbn));
  flash_dev_model u_dev (.clk_in(clk), .pins_in(pins), .addr_in(ad),
    .dq_in(dq_i), .dq_out(dq_d), .ready_busy_n_out(rbn));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic note(input logic ok, input logic [31:0] g, x);
    checks_done++;
    if (!ok) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : note
  task automatic chk(input logic [DATA_W-1:0] g, x);
    note(g === x, 32'(g), 32'(x));
  endtask : chk
  task automatic chka(input logic [ADDR_W-1:0] g, x);
    note(g === x, 32'(g), 32'(x));
  endtask : chka
  task automatic chk1(input logic g, x);
    note(g === x, 32'(g), 32'(x));
  endtask : chk1
  // request is held until an edge that sees ready high
  task automatic op(input op_t o, input logic bm, input logic lsb,
    input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] x);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    req = '{op: o, byte_mode: bm, addr: a, byte_lsb: lsb, data: d};
    vld = 1'b1;
    exp_q.push_back(x);
    if (o == OP_READ) last_rd = x;
    do begin
      @(negedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 3000);
    if (n >= 3000) bad_count++;
    @(posedge clk);
    #1;
    vld = 1'b0;
  endtask : op
  task automatic wait_on(input logic want_rsp);
    int n;
    n = 0;
    // the busy flag lags the pin by the two sync stages
    if (!want_rsp) repeat (3) @(negedge clk);
    while ((want_rsp ? rv !== 1'b1 : dbusy !== 1'b0) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) bad_count++;
  endtask : wait_on
  task automatic close_out();
    if (exp_q.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // the oldest note is compared whenever an answer appears
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      if (exp_q.size() == 0) note(1'b0, 32'(rd), 32'h0);
      else chk(rd, exp_q.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    vld = 1'b0;
    req = '0;
    a = '0;
    last_rd = '0;
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    chk({10'h000, pins}, {10'h000, PINS_IDLE});
    chk(dq_oe_n, FLOAT_OE_N);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      a = r[ADDR_W-1:0];
      w = a[15:0] ^ 16'ha5c3;
      if (i < 8) op(OP_READ, 1'b0, 1'b0, '0, w);
      else op(OP_READ, 1'b1, r[31], '0,
        {8'h00, r[31] ? w[15:8] : w[7:0]});
    end
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      a = r[ADDR_W-1:0];
      op(OP_WRITE, 1'b0, 1'b0, r[31:16], last_rd);
      wait_on(1'b1);
      chka(u_dev.wr_addr, a);
      chk(u_dev.wr_data, r[31:16]);
      if (k == 0) begin
        op(OP_READ, 1'b0, 1'b0, '0, 16'h0080);
        wait_on(1'b1);
        chk1(dbusy, 1'b1);
      end else begin
        repeat (4) @(posedge clk);
        op(OP_RESET, 1'b0, 1'b0, '0, last_rd);
        wait_on(1'b1);
        chk1(intr, 1'b1);
        chk1(rbn, 1'b1);
        op(OP_READ, 1'b0, 1'b0, '0, a[15:0] ^ 16'ha5c3);
        op(OP_WRITE, 1'b0, 1'b0, r[15:0], last_rd);
        wait_on(1'b1);
        chk1(intr, 1'b0);
      end
      wait_on(1'b0);
    end
    op(OP_RESET, 1'b0, 1'b0, '0, last_rd);
    wait_on(1'b1);
    chk1(intr, 1'b0);
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      a = r[ADDR_W-1:0];
      e = a;
      e[SECT_SEL_BIT] = k[0];
      e[SECT_MID_BIT] = 1'b1;
      e[SECT_LOW_BIT] = 1'b0;
      po = OP_UNPROTECT;
      if (k == 0) po = OP_PROTECT;
      op(po, 1'b0, 1'b0, r[15:0], last_rd);
      wait_on(1'b1);
      chka(u_dev.wr_addr, e);
      chk1(u_dev.wr_hv, 1'b1);
    end
    op(OP_WRITE, 1'b0, 1'b0, {8'h00, u_dev.ID_ENTER}, last_rd);
    wait_on(1'b1);
    wait_on(1'b0);
    op(OP_READ, 1'b0, 1'b0, '0, {8'h00, u_dev.ID_CODE});
    wait_on(1'b1);
    repeat (30) @(posedge clk);
    close_out();
  end
endmodule : flash_host_tb
